//--- common/psfu_defines.svh
// constants for the procedure stack frame unit
`ifndef PSFU_DEFINES_SVH
`define PSFU_DEFINES_SVH
`define PSFU_MARKER_WORDS     16'h0003
`define PSFU_STACK_LIMIT      16'h7FFF
`define PSFU_RP_EMPTY         3'h7
`define PSFU_LMINUS_SPAN      5'h1F
`define PSFU_RET_P_OFS        16'h0002
`define PSFU_RET_ENV_OFS      16'h0001
`define PSFU_MEM_LAT_CYC      1
`endif

//--- common/psfu_pkg.sv
// types for the procedure stack frame unit
package psfu_pkg;
  typedef enum logic [3:0]
  {
    PSFU_ADJ  = 4'h0,
    PSFU_CALL = 4'h1,
    PSFU_EXIT = 4'h2,
    PSFU_PUSH = 4'h3,
    PSFU_POP  = 4'h4,
    PSFU_LDI  = 4'h5,
    PSFU_LOAD_ADDRESS_OP = 4'h6,
    PSFU_MREF = 4'h7
  } psfu_op_e;

  typedef enum logic [1:0]
  {
    PSFU_M_LPLUS  = 2'h0,
    PSFU_M_LMINUS = 2'h1,
    PSFU_M_GLOBAL = 2'h2
  } psfu_mode_e;

  typedef struct packed
  {
    psfu_op_e   op;
    psfu_mode_e mode;
    logic       indirect;
    logic       indexed;
    logic [15:0] operand;
    logic [15:0] index;
    logic [2:0]  count;
    logic [15:0] target;
  } psfu_cmd_s;

  typedef struct packed
  {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } psfu_mem_s;
endpackage

//--- sim/procedure_stack_frame_unit_tb.sv
// self-checking testbench for the procedure stack frame unit
`timescale 1ns/100ps
module procedure_stack_frame_unit_tb;
  logic                 clock;
  logic                 rst;
  logic                 cmd_valid;
  logic                 cmd_ready;
  psfu_pkg::psfu_cmd_s  cmd;
  logic [15:0]          pc_in;
  logic [15:0]          env_in;
  logic                 init_load;
  logic [15:0]          init_base;
  psfu_pkg::psfu_mem_s  mem;
  logic [15:0]          mem_rdata;
  logic [15:0]          local_base;
  logic [15:0]          stack_top;
  logic [15:0]          pc_out;
  logic                 pc_load;
  logic [15:0]          env_out;
  logic                 env_load;
  logic [15:0]          operand_out;
  logic                 operand_valid;
  logic                 overflow_trap;
  logic [2:0]           register_stack_pointer;
  logic [127:0]         register_stack;
  logic [15:0]          ram [65536];
  int                   failures;
  int                   n_checks;
  int                   cyc;
  int                   pc_hits;
  int                   env_hits;
  int                   op_hits;
  int                   trap_hits;
  logic [15:0]          pc_last;
  logic [15:0]          env_last;
  logic [15:0]          op_last;

  psfu_frame_unit dut_u (
    .clock                  (clock),
    .rst                    (rst),
    .cmd_valid              (cmd_valid),
    .cmd_ready              (cmd_ready),
    .cmd                    (cmd),
    .pc_in                  (pc_in),
    .env_in                 (env_in),
    .init_load              (init_load),
    .init_base              (init_base),
    .mem                    (mem),
    .mem_rdata              (mem_rdata),
    .local_base             (local_base),
    .stack_top              (stack_top),
    .pc_out                 (pc_out),
    .pc_load                (pc_load),
    .env_out                (env_out),
    .env_load               (env_load),
    .operand_out            (operand_out),
    .operand_valid          (operand_valid),
    .overflow_trap          (overflow_trap),
    .register_stack_pointer (register_stack_pointer),
    .register_stack         (register_stack)
  );

  // ***********************************
  // clock, memory and pulse monitors
  // ***********************************
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // writes land on the edge; reads answer within the request cycle
  always @(posedge clock)
  begin
    if (mem.req && mem.we)
      ram[mem.addr] <= mem.wdata;
  end

  assign mem_rdata = (mem.req && !mem.we) ? ram[mem.addr] : 16'hDEAD;

  always @(negedge clock)
  begin
    if (pc_load === 1'b1)
    begin
      pc_hits++;
      pc_last = pc_out;
    end
    if (env_load === 1'b1)
    begin
      env_hits++;
      env_last = env_out;
    end
    if (operand_valid === 1'b1)
    begin
      op_hits++;
      op_last = operand_out;
    end
    if (overflow_trap === 1'b1)
      trap_hits++;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      give_verdict();
    end
  end

  // ***********************************
  // helpers
  // ***********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic psfu_pkg::psfu_cmd_s mk(input psfu_pkg::psfu_op_e op,
      input logic [1:0] md, input logic ind, input logic idx,
      input logic [15:0] opd, input logic [15:0] ix, input logic [2:0] n);
    psfu_pkg::psfu_cmd_s c;
    c.op = op;
    c.mode = psfu_pkg::psfu_mode_e'(md);
    c.indirect = ind;
    c.indexed = idx;
    c.operand = opd;
    c.index = ix;
    c.count = n;
    c.target = 16'h0CCC;
    return c;
  endfunction

  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50)
    begin
      @(negedge clock);
      k++;
    end
    if (k == 50)
      chk(32'h0, 32'h1);
  endtask

  task automatic run(input psfu_pkg::psfu_cmd_s c);
    wait_ready();
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    @(negedge clock);
    wait_ready();
    @(negedge clock);
  endtask

  task automatic set_base(input logic [15:0] b);
    init_base = b;
    init_load = 1'b1;
    @(negedge clock);
    init_load = 1'b0;
    @(negedge clock);
  endtask

  function automatic logic [15:0] ent(input int i);
    return register_stack[16*i +: 16];
  endfunction

  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_build();
    set_base(16'h0100);
    chk(local_base, 16'h0100);
    cmd = mk(psfu_pkg::PSFU_ADJ, 2'h0, 1'b0, 1'b0, 16'h0001, 16'h0000, 3'h0);
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd = mk(psfu_pkg::PSFU_ADJ, 2'h0, 1'b0, 1'b0, 16'h0020, 16'h0000, 3'h0);
    @(negedge clock);
    cmd_valid = 1'b0;
    @(negedge clock);
    chk(stack_top, 16'h0121);
    chk(local_base, 16'h0100);
    run(mk(psfu_pkg::PSFU_LDI, 2'h0, 1'b0, 1'b0, 16'h0005, 16'h0000, 3'h0));
    chk({register_stack_pointer, ent(0)}, {3'h0, 16'h0005});
    run(mk(psfu_pkg::PSFU_LOAD_ADDRESS_OP, 2'h0, 1'b0, 1'b0, 16'h0004, 16'h0000, 3'h0));
    chk({register_stack_pointer, ent(1)}, {3'h1, 16'h0104});
    run(mk(psfu_pkg::PSFU_PUSH, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 3'h2));
    chk({ram[16'h0122], ram[16'h0123]}, {16'h0005, 16'h0104});
    chk({register_stack_pointer, stack_top}, {3'h7, 16'h0123});
    $display("test build done");
  endtask

  task automatic t_call();
    int h;
    h = pc_hits;
    pc_in = 16'h0AAA;
    env_in = 16'h0BBB;
    run(mk(psfu_pkg::PSFU_CALL, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 3'h0));
    chk(ram[16'h0124], 16'h0AAA);
    chk(ram[16'h0125], 16'h0BBB);
    chk(ram[16'h0126], 16'h0100);
    chk({local_base, stack_top}, {16'h0126, 16'h0126});
    chk(pc_hits - h, 32'h1);
    chk(pc_last, 16'h0CCC);
    chk(register_stack_pointer, 3'h7);
    $display("test call done");
  endtask

  task automatic t_access();
    int h;
    h = op_hits;
    run(mk(psfu_pkg::PSFU_MREF, 2'h1, 1'b0, 1'b0, 16'h0003, 16'h0000, 3'h0));
    chk(op_last, 16'h0104);
    run(mk(psfu_pkg::PSFU_MREF, 2'h1, 1'b1, 1'b0, 16'h0003, 16'h0000, 3'h0));
    chk(op_last, 16'h1234);
    run(mk(psfu_pkg::PSFU_MREF, 2'h1, 1'b0, 1'b0, 16'h001F, 16'h0000, 3'h0));
    chk(op_last, 16'h0BAD);
    run(mk(psfu_pkg::PSFU_MREF, 2'h0, 1'b0, 1'b1, 16'h0001, 16'h0002, 3'h0));
    chk(op_last, 16'h4321);
    run(mk(psfu_pkg::PSFU_MREF, 2'h2, 1'b0, 1'b0, 16'h0104, 16'h0000, 3'h0));
    chk(op_last, 16'h1234);
    chk(op_hits - h, 32'h5);
    $display("test access done");
  endtask

  task automatic t_exit();
    run(mk(psfu_pkg::PSFU_LDI, 2'h0, 1'b0, 1'b0, 16'h0019, 16'h0000, 3'h0));
    run(mk(psfu_pkg::PSFU_EXIT, 2'h0, 1'b0, 1'b0, 16'h0005, 16'h0000, 3'h0));
    chk({local_base, stack_top}, {16'h0100, 16'h0121});
    chk({pc_last, env_last}, {16'h0AAA, 16'h0BBB});
    chk({register_stack_pointer, ent(0)}, {3'h0, 16'h0019});
    $display("test exit done");
  endtask

  task automatic t_pop();
    run(mk(psfu_pkg::PSFU_LDI, 2'h0, 1'b0, 1'b0, 16'h0022, 16'h0000, 3'h0));
    run(mk(psfu_pkg::PSFU_PUSH, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 3'h2));
    chk({ram[16'h0122], ram[16'h0123]}, {16'h0019, 16'h0022});
    ram[16'h0122] = 16'h0066;
    ram[16'h0123] = 16'h0077;
    run(mk(psfu_pkg::PSFU_POP, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 3'h2));
    chk({ent(1), ent(0)}, {16'h0077, 16'h0066});
    chk({register_stack_pointer, stack_top}, {3'h1, 16'h0121});
    run(mk(psfu_pkg::PSFU_LOAD_ADDRESS_OP, 2'h2, 1'b0, 1'b0, 16'h0345, 16'h0000, 3'h0));
    chk({register_stack_pointer, ent(2)}, {3'h2, 16'h0345});
    $display("test pop done");
  endtask

  task automatic t_trap();
    logic [15:0] b;
    int h;
    for (int i = 0; i < 2; i++)
    begin
      b = 16'h7FFC + 16'(i);
      set_base(b);
      h = trap_hits;
      run(mk(psfu_pkg::PSFU_CALL, 2'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 3'h0));
      chk(trap_hits - h, 32'(i));
      chk(stack_top, (i == 1) ? b : b + 16'h0003);
      chk(local_base, (i == 1) ? b : b + 16'h0003);
    end
    $display("test trap done");
  endtask

  // ***********************************
  // main sequence
  // ***********************************
  initial
  begin
    failures = 0;
    n_checks = 0;
    cyc = 0;
    pc_hits = 0;
    env_hits = 0;
    op_hits = 0;
    trap_hits = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    pc_in = 16'h0000;
    env_in = 16'h0000;
    init_load = 1'b0;
    init_base = 16'h0000;
    ram[16'h0104] = 16'h1234;
    ram[16'h0107] = 16'h0BAD;
    ram[16'h0129] = 16'h4321;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    chk({local_base, stack_top}, 32'h0);
    chk({cmd_ready, register_stack_pointer}, {1'b1, 3'h7});
    t_build();
    t_call();
    t_access();
    t_exit();
    t_pop();
    t_trap();
    give_verdict();
  end
endmodule

//--- src/psfu_frame_unit.sv
// procedure stack frame unit: local base and stack top pointer logic
//
// Overview of operation
// RULE1: call writes three-word marker starting just above stack top.
// RULE2: after marker, local base and stack top both point at marker word three.
// RULE3: return restores caller base; stack top becomes base minus decrement.
// RULE4: stack adjust stack_adjust_op immediate to stack top; octal 40 gives 32 words.
// RULE5: push stores register entries above stack top, stack_adjust_op word count.
// RULE6: pop reloads register entries from stack top, subtracts word count.
// RULE7: allocating locals changes only stack top, never local base.
// RULE8: local-plus addresses are positive offsets from base, direct, pointer or indexed.
// RULE9: local-minus reaches base down to 31 below; 29 parameter words.
// RULE10: indirect bit 0 uses word as operand, 1 as pointer; indexing allowed.
// RULE11: load address places global-relative operand address on register top; code forms local-plus or local-minus addresses by mode too.
// RULE12: load immediate places immediate on register top.
// RULE13: loader sets globals and both pointers above global area first.
// RULE14: return value stays on register top across return.
// RULE15: call with new stack top above 32767 traps and aborts.
// RULE16: call ends with register stack pointer set to seven.
// RULE17: return loads program counter from base-2, base from base word.
// RULE18: 16-bit pointer arithmetic; update done before next command taken.
// RULE19: marker holds return counter, environment word, caller base in order.
`timescale 1ns/100ps
`include "psfu_defines.svh"
module psfu_frame_unit (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // command
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire psfu_pkg::psfu_cmd_s cmd,
  // processor state feed
  input  wire logic [15:0]         pc_in,
  input  wire logic [15:0]         env_in,
  input  wire logic                init_load,
  input  wire logic [15:0]         init_base,
  // memory
  output psfu_pkg::psfu_mem_s      mem,
  input  wire logic [15:0]         mem_rdata,
  // results
  output logic [15:0]              local_base,
  output logic [15:0]              stack_top,
  output logic [15:0]              pc_out,
  output logic                     pc_load,
  output logic [15:0]              env_out,
  output logic                     env_load,
  output logic [15:0]              operand_out,
  output logic                     operand_valid,
  output logic                     overflow_trap,
  output logic [2:0]               register_stack_pointer,
  output logic [127:0]             register_stack
);
  typedef enum logic [5:0]
  {
    S_IDLE = 6'b000001,
    S_MARK = 6'b000010,
    S_XFER = 6'b000100,
    S_EXIT = 6'b001000,
    S_PTR  = 6'b010000,
    S_DONE = 6'b100000
  } psfu_st_e;

  psfu_st_e st_r;
  psfu_pkg::psfu_cmd_s cmd_r;
  logic [15:0] l_r;
  logic [15:0] s_r;
  logic [2:0]  cnt_r;
  logic [15:0] ptr_r;
  logic [15:0] pc_r;
  logic        pc_ld_r;
  logic [15:0] env_r;
  logic        env_ld_r;
  logic [15:0] opnd_r;
  logic        opnd_v_r;
  logic        trap_r;
  psfu_pkg::psfu_mem_s mem_r;
  logic        rs_we;
  logic [2:0]  rs_idx;
  logic [15:0] rs_data;
  logic        rp_ld;
  logic [2:0]  rp_val;
  logic [2:0]  rp;
  logic [127:0] rs_ent;
  logic [15:0] ea;
  logic [15:0] s_call;
  logic        xfer_last;

  psfu_regstack #(.DEPTH(8)) u_rs (
    .clock    (clock),
    .rst      (rst),
    .wr_en    (rs_we),
    .wr_idx   (rs_idx),
    .wr_data  (rs_data),
    .rp_load  (rp_ld),
    .rp_value (rp_val),
    .rp       (rp),
    .entries  (rs_ent)
  );

  assign cmd_ready = (st_r == S_IDLE); // RULE18
  assign s_call = s_r + `PSFU_MARKER_WORDS; // RULE2
  // pop needs one extra cycle: read data lands a cycle after its request
  assign xfer_last = (cmd_r.op == psfu_pkg::PSFU_PUSH) ? (cnt_r == cmd_r.count - 3'h1)
                                                       : (cnt_r == cmd_r.count); // RULE6

  // ****************************************
  // effective address
  // ****************************************
  always_comb
  begin
    unique case (cmd_r.mode)
      psfu_pkg::PSFU_M_LPLUS:  ea = l_r + cmd_r.operand; // RULE8
      psfu_pkg::PSFU_M_LMINUS: ea = l_r - {11'h000, cmd_r.operand[4:0]}; // RULE9
      default:                 ea = cmd_r.operand; // RULE11
    endcase
  end

  // ****************************************
  // sequencer and pointers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r <= S_IDLE;
      cmd_r <= '0;
      l_r <= 16'h0000;
      s_r <= 16'h0000;
      cnt_r <= 3'h0;
      ptr_r <= 16'h0000;
    end
    else
    begin
      unique case (st_r)
        S_IDLE:
        begin
          if (init_load)
          begin
            l_r <= init_base; // RULE13
            s_r <= init_base;
          end
          else if (cmd_valid)
          begin
            cmd_r <= cmd;
            cnt_r <= 3'h0;
            unique case (cmd.op)
              psfu_pkg::PSFU_ADJ:  s_r <= s_r + cmd.operand; // RULE4 RULE7
              psfu_pkg::PSFU_CALL: st_r <= S_MARK;
              psfu_pkg::PSFU_EXIT: st_r <= S_EXIT;
              psfu_pkg::PSFU_PUSH, psfu_pkg::PSFU_POP:
                st_r <= (cmd.count == 3'h0) ? S_IDLE : S_XFER;
              psfu_pkg::PSFU_MREF: st_r <= S_PTR;
              default:             st_r <= S_IDLE;
            endcase
          end
        end
        S_MARK:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h2)
          begin
            st_r <= S_IDLE;
            if (s_call <= `PSFU_STACK_LIMIT) // RULE15
            begin
              l_r <= s_call; // RULE2
              s_r <= s_call;
            end
          end
        end
        S_XFER:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (xfer_last)
          begin
            st_r <= S_IDLE;
            if (cmd_r.op == psfu_pkg::PSFU_PUSH)
              s_r <= s_r + {13'h0000, cmd_r.count}; // RULE5
            else
              s_r <= s_r - {13'h0000, cmd_r.count}; // RULE6
          end
        end
        S_EXIT:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h0)
            s_r <= l_r - cmd_r.operand; // RULE3
          if (cnt_r == 3'h3)
          begin
            l_r <= mem_rdata; // RULE17
            st_r <= S_IDLE;
          end
        end
        S_PTR:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h1)
          begin
            ptr_r <= mem_rdata;
            st_r <= cmd_r.indirect ? S_DONE : S_IDLE; // RULE10
          end
        end
        S_DONE:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h3)
            st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // memory requests
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
      mem_r <= '0;
    else
    begin
      mem_r <= '0;
      unique case (st_r)
        S_MARK:
        begin
          mem_r.req <= 1'b1;
          mem_r.we <= 1'b1;
          mem_r.addr <= s_r + {13'h0000, cnt_r} + 16'h0001; // RULE1
          unique case (cnt_r)
            3'h0:    mem_r.wdata <= pc_in; // RULE19
            3'h1:    mem_r.wdata <= env_in;
            default: mem_r.wdata <= l_r;
          endcase
        end
        S_XFER:
        begin
          mem_r.req <= (cmd_r.op == psfu_pkg::PSFU_PUSH) || !xfer_last;
          mem_r.we <= (cmd_r.op == psfu_pkg::PSFU_PUSH);
          if (cmd_r.op == psfu_pkg::PSFU_PUSH)
          begin
            mem_r.addr <= s_r + {13'h0000, cnt_r} + 16'h0001; // RULE5
            mem_r.wdata <= rs_ent[cnt_r*16 +: 16];
          end
          else
            mem_r.addr <= s_r - {13'h0000, cnt_r}; // RULE6
        end
        S_EXIT:
          if (cnt_r < 3'h3)
          begin
            mem_r.req <= 1'b1;
            unique case (cnt_r)
              3'h0:    mem_r.addr <= l_r - `PSFU_RET_P_OFS; // RULE17
              3'h1:    mem_r.addr <= l_r - `PSFU_RET_ENV_OFS;
              default: mem_r.addr <= l_r;
            endcase
          end
        S_PTR:
          if (cnt_r == 3'h0)
          begin
            mem_r.req <= 1'b1;
            mem_r.addr <= ea + (cmd_r.indexed && !cmd_r.indirect ? cmd_r.index : 16'h0000);
          end
        S_DONE:
          if (cnt_r == 3'h2)
          begin
            mem_r.req <= 1'b1;
            mem_r.addr <= ptr_r + (cmd_r.indexed ? cmd_r.index : 16'h0000); // RULE10
          end
        default: mem_r <= '0;
      endcase
    end
  end

  // ****************************************
  // results and register stack writes
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pc_r <= 16'h0000;
      pc_ld_r <= 1'b0;
      env_r <= 16'h0000;
      env_ld_r <= 1'b0;
      opnd_r <= 16'h0000;
      opnd_v_r <= 1'b0;
      trap_r <= 1'b0;
    end
    else
    begin
      pc_ld_r <= 1'b0;
      env_ld_r <= 1'b0;
      opnd_v_r <= 1'b0;
      trap_r <= 1'b0;
      if (st_r == S_MARK && cnt_r == 3'h2)
      begin
        trap_r <= (s_call > `PSFU_STACK_LIMIT); // RULE15
        pc_r <= cmd_r.target;
        pc_ld_r <= (s_call <= `PSFU_STACK_LIMIT);
      end
      if (st_r == S_EXIT && cnt_r == 3'h1)
      begin
        pc_r <= mem_rdata; // RULE17
        pc_ld_r <= 1'b1;
      end
      if (st_r == S_EXIT && cnt_r == 3'h2)
      begin
        env_r <= mem_rdata;
        env_ld_r <= 1'b1;
      end
      if ((st_r == S_PTR && cnt_r == 3'h1 && !cmd_r.indirect) ||
          (st_r == S_DONE && cnt_r == 3'h3))
      begin
        opnd_r <= mem_rdata; // RULE10
        opnd_v_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rs_we = 1'b0;
    rs_idx = rp + 3'h1;
    rs_data = cmd.operand;
    rp_ld = 1'b0;
    rp_val = rp + 3'h1;
    if (st_r == S_IDLE && !init_load && cmd_valid)
    begin
      if (cmd.op == psfu_pkg::PSFU_LDI)
      begin
        rs_we = 1'b1; // RULE12
        rp_ld = 1'b1;
      end
      else if (cmd.op == psfu_pkg::PSFU_LOAD_ADDRESS_OP)
      begin
        rs_we = 1'b1; // RULE11
        rp_ld = 1'b1;
        unique case (cmd.mode)
          psfu_pkg::PSFU_M_LPLUS:  rs_data = l_r + cmd.operand;
          psfu_pkg::PSFU_M_LMINUS: rs_data = l_r - {11'h000, cmd.operand[4:0]};
          default:                 rs_data = cmd.operand;
        endcase
      end
    end
    else if (st_r == S_XFER && cmd_r.op == psfu_pkg::PSFU_POP && cnt_r != 3'h0)
    begin
      rs_we = 1'b1; // RULE6
      rs_idx = cmd_r.count - cnt_r;
      rs_data = mem_rdata;
    end
    if (st_r == S_XFER && xfer_last)
    begin
      rp_ld = 1'b1;
      rp_val = (cmd_r.op == psfu_pkg::PSFU_PUSH) ? `PSFU_RP_EMPTY : cmd_r.count - 3'h1;
    end
    if (st_r == S_MARK && cnt_r == 3'h2 && s_call <= `PSFU_STACK_LIMIT)
    begin
      rp_ld = 1'b1; // RULE16
      rp_val = `PSFU_RP_EMPTY;
    end
  end

  assign mem = mem_r;
  assign local_base = l_r;
  assign stack_top = s_r;
  assign pc_out = pc_r;
  assign pc_load = pc_ld_r;
  assign env_out = env_r;
  assign env_load = env_ld_r;
  assign operand_out = opnd_r;
  assign operand_valid = opnd_v_r;
  assign overflow_trap = trap_r;
  assign register_stack_pointer = rp; // RULE14
  assign register_stack = rs_ent;

  // ****************************************
  // checks
  // ****************************************
  a_adjust_stack_adjust_op: assert property (@(posedge clock) disable iff (rst) // RULE4
    st_r == S_IDLE && cmd_valid && !init_load && cmd.op == psfu_pkg::PSFU_ADJ
    |=> s_r == $past(s_r) + $past(cmd.operand) && l_r == $past(l_r))
    else $error("stack adjust result wrong");
  a_call_ptrs: assert property (@(posedge clock) disable iff (rst) // RULE2
    st_r == S_MARK && cnt_r == 3'h2 && s_call <= 16'h7FFF
    |=> l_r == $past(s_call) && s_r == $past(s_call) && rp == 3'h7)
    else $error("call pointers wrong");
  a_call_trap: assert property (@(posedge clock) disable iff (rst) // RULE15
    st_r == S_MARK && cnt_r == 3'h2 && s_call > 16'h7FFF
    |=> overflow_trap && $stable(l_r) && !pc_load)
    else $error("overflow not trapped");
  a_exit_top: assert property (@(posedge clock) disable iff (rst) // RULE3
    st_r == S_EXIT && cnt_r == 3'h0 |=> s_r == $past(l_r) - cmd_r.operand)
    else $error("exit stack top wrong");
  a_exit_pcaddr: assert property (@(posedge clock) disable iff (rst) // RULE17
    st_r == S_EXIT && cnt_r == 3'h0 |=> mem.req && mem.addr == l_r - 16'h0002)
    else $error("return counter address wrong");
  a_marker_first: assert property (@(posedge clock) disable iff (rst) // RULE1
    st_r == S_MARK && cnt_r == 3'h0 |=> mem.we && mem.addr == s_r + 16'h0001
    && mem.wdata == $past(pc_in))
    else $error("marker write wrong");
  a_push_count: assert property (@(posedge clock) disable iff (rst) // RULE5
    st_r == S_XFER && cmd_r.op == psfu_pkg::PSFU_PUSH && cnt_r == cmd_r.count - 3'h1
    |=> s_r == $past(s_r) + {13'h0000, $past(cmd_r.count)})
    else $error("push count wrong");
  a_pop_count: assert property (@(posedge clock) disable iff (rst) // RULE6
    st_r == S_XFER && cmd_r.op == psfu_pkg::PSFU_POP && cnt_r == cmd_r.count
    |=> s_r == $past(s_r) - {13'h0000, $past(cmd_r.count)})
    else $error("pop count wrong");
  a_ldi_top: assert property (@(posedge clock) disable iff (rst) // RULE12
    st_r == S_IDLE && cmd_valid && !init_load && cmd.op == psfu_pkg::PSFU_LDI
    |=> rs_ent[rp*16 +: 16] == $past(cmd.operand))
    else $error("immediate not on top");
endmodule

//--- src/psfu_regstack.sv
// register stack with pointer, written by the frame unit
`timescale 1ns/100ps
`include "psfu_defines.svh"
module psfu_regstack #(
  parameter int DEPTH = 8
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  // pointer control
  input  wire logic        rp_load,
  input  wire logic [2:0]  rp_value,
  // state
  output logic      [2:0]  rp,
  output logic      [DEPTH*16-1:0] entries
);
  generate
    if (DEPTH != 8)
    begin : g_depth_chk
      $error("register stack depth must be 8");
    end
  endgenerate

  logic [2:0] rp_r;
  logic [15:0] ent_r [DEPTH];

  always_ff @(posedge clock)
  begin
    if (rst)
      rp_r <= `PSFU_RP_EMPTY;
    else if (rp_load)
      rp_r <= rp_value;
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
      always_ff @(posedge clock)
      begin
        if (rst)
          ent_r[gi] <= 16'h0000;
        else if (wr_en && wr_idx == 3'(gi))
          ent_r[gi] <= wr_data;
      end
      assign entries[gi*16 +: 16] = ent_r[gi];
    end
  endgenerate

  assign rp = rp_r;
endmodule
